//--- rtl/ecpph_pkg.sv
// constants and types of the extended capabilities parallel port
// Contract
// - one shared 16-byte FIFO serves both transfer directions
// - buffered bytes go out with a hardware compatibility strobe handshake
// - reverse run-length byte is consumed, next byte delivered repeatedly
// - no negotiation; DMA burst channel forward and reverse
// - forward: byte on data lines, strobe asserted, interlocked with busy
// - host ack requests reverse bytes; forward it tags command or data
// - init line low selects reverse, high selects forward
// - peripheral acks reverse on perror; host drives data only if permitted
// - select-in stays deasserted throughout ECP mode
// - fault asserted gives error interrupt, forward only
// - three low offsets and +402h always decoded; +400h and +401h depend on mode
// - +400h: compat FIFO, ECP FIFO, test FIFO, or configuration A
// - address is base plus offset; extended set via upper address bit
// - registers answer only when AEN marks a non-DMA I/O cycle
// - mode field codes: 000 to 111 as listed modes
// - mode field is read/write bits 7 to 5 of extended control
// - no hardware compression; compression bit reads low
package ecpph_pkg;
  // ----------------------------------------------------------------
  // register offsets from the port base
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_DATA = 16'h0000;
  localparam logic [15:0] OFF_DSR = 16'h0001;
  localparam logic [15:0] OFF_DCR = 16'h0002;
  localparam logic [15:0] OFF_FIFO = 16'h0400;
  localparam logic [15:0] OFF_CONFIGURATION_B = 16'h0401;
  localparam logic [15:0] OFF_ECR = 16'h0402;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int DCR_STROBE = 0;
  localparam int DCR_AUTOFD = 1;
  localparam int DCR_INIT = 2;
  localparam int DCR_SELIN = 3;
  localparam int DCR_DIR = 5;
  localparam int ECTL_NERR = 2;
  localparam int ECTL_DMAEN = 1;
  localparam int ECTL_SVC = 0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] DCR_RST = 6'h00;
  localparam logic [5:0] ECTL_RST = 6'h05;
  localparam logic [7:0] CONFIGURATION_A_VAL = 8'h10;
  localparam int FIFO_DEPTH = 16;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int STB_NS = 500;
  localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // modes and state machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SPP = 3'h0, MODE_BIDIR = 3'h1, MODE_COMPAT_FIFO_PORT = 3'h2,
    MODE_ECP = 3'h3, MODE_EPP = 3'h4, MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6, MODE_CNFG = 3'h7
  } ecpph_mode_t;
  typedef enum logic [3:0] {
    FW_IDLE = 4'h1, FW_SETUP = 4'h2, FW_STB = 4'h4, FW_HOLD = 4'h8
  } ecpph_fwd_t;
  typedef enum logic [3:0] {
    RV_IDLE = 4'h1, RV_REQ = 4'h2, RV_ACK = 4'h4, RV_RPT = 4'h8
  } ecpph_rev_t;
endpackage

//--- rtl/ecpph_port.sv
// extended capabilities parallel port, host adapter side
module ecpph_port #(
  parameter logic [15:0] BASE_ADDR = 16'h0378,
  parameter int DEPTH = ecpph_pkg::FIFO_DEPTH,
  parameter int WR_THRESH = 8,
  parameter int RD_THRESH = 8
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [15:0] isaAddr,
  input wire logic aen,
  input wire logic iorN,
  input wire logic iowN,
  input wire logic [7:0] isaDin,
  output logic [7:0] isaDout,
  output logic isaDoutEn,
  input wire logic dmaAckN,
  input wire logic dmaTc,
  output logic dmaReq,
  input wire logic [7:0] pdIn,
  output logic [7:0] pdOut,
  output logic pdOe,
  output logic strobeN,
  output logic autoFdN,
  output logic initN,
  output logic selectInN,
  input wire logic ackN,
  input wire logic busy,
  input wire logic pError,
  input wire logic select,
  input wire logic faultN,
  output logic errIntr
);
  import ecpph_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] WR_TH_C = (AW+1)'(WR_THRESH);
  localparam logic [AW:0] RD_TH_C = (AW+1)'(RD_THRESH);
  localparam logic [6:0] STB_C = 7'(STB_CYC);

  function automatic logic hitOff(input logic [15:0] a, input logic [15:0] o,
                                  input logic en);
    hitOff = en && (a == BASE_ADDR + o);
  endfunction

  logic [7:0] dataReg_r, isaDout_r, pdOut_r, lastRd_r, rptByte_r, pdPin_r;
  logic [5:0] dcr_r, ectl_r;
  logic [8:0] fifoMem [DEPTH];
  logic [AW-1:0] wrPtr_r, rdPtr_r;
  logic [AW:0] cnt_r;
  logic iorPrev_r, iowPrev_r, faultPrev_r, tag_r;
  logic isaDoutEn_r, dmaReq_r, pdOe_r, strobeN_r, autoFdN_r;
  logic initN_r, selectInN_r, errIntr_r, rlePend_r;
  logic [6:0] stbCnt_r, rleCnt_r, rptLeft_r;
  ecpph_fwd_t fwSt_r;
  ecpph_rev_t rvSt_r;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire ecpph_mode_t mode = ecpph_mode_t'(ectl_r[5:3]);
  wire fifoMode = (mode == MODE_COMPAT_FIFO_PORT) || (mode == MODE_ECP) ||
                  (mode == MODE_TEST);
  wire dir = dcr_r[DCR_DIR] && (mode != MODE_SPP) && (mode != MODE_COMPAT_FIFO_PORT);
  wire ioCyc = !aen;
  wire dmaCyc = !dmaAckN && fifoMode;
  wire iowStart = iowPrev_r && !iowN;
  wire iorStart = iorPrev_r && !iorN;
  // upper address bit selects the extended set
  wire hData = hitOff(isaAddr, OFF_DATA, ioCyc);
  wire hDsr = hitOff(isaAddr, OFF_DSR, ioCyc);
  wire hDcr = hitOff(isaAddr, OFF_DCR, ioCyc);
  wire hFifo = hitOff(isaAddr, OFF_FIFO, ioCyc);
  wire hCnfgB = hitOff(isaAddr, OFF_CONFIGURATION_B, ioCyc);
  wire hEcr = hitOff(isaAddr, OFF_ECR, ioCyc);
  wire anyHit = hData || hDsr || hDcr || hFifo || hCnfgB || hEcr;
  wire full = (cnt_r == DEPTH_C);
  wire empty = (cnt_r == '0);
  wire [8:0] head = fifoMem[rdPtr_r];
  wire [AW:0] freeCnt = DEPTH_C - cnt_r;

  wire aFifoWr = iowStart && hData && (mode == MODE_ECP);
  wire dFifoWr = iowStart && ((hFifo && fifoMode) || dmaCyc);
  wire hostRd = iorStart && ((hFifo && (mode == MODE_ECP ||
                mode == MODE_TEST)) || dmaCyc);
  wire dataWr = iowStart && hData &&
                (mode == MODE_SPP || mode == MODE_BIDIR);
  wire ecrWr = iowStart && hEcr;
  wire flush = ecrWr && (isaDin[7:6] == 2'b00);

  // ----------------------------------------------------------------
  // shared FIFO
  // ----------------------------------------------------------------
  wire fwdMode = (mode == MODE_COMPAT_FIFO_PORT) || (mode == MODE_ECP && !dir);
  wire revMode = (mode == MODE_ECP) && dir && !pError;
  wire fwdPop = (fwSt_r == FW_IDLE) && fwdMode && !empty && !busy;
  wire rvCapture = (rvSt_r == RV_REQ) && !ackN;
  wire rvData = rvCapture && busy;
  wire rptPush = (rvSt_r == RV_RPT) && !full && (rptLeft_r != '0);
  wire revPush = (rvData && !full) || rptPush;
  wire hostPush = (aFifoWr || dFifoWr) && !full && !revPush;
  wire doPush = revPush || hostPush;
  wire [8:0] pushWord = revPush ? {1'b0, (rptPush ? rptByte_r : pdIn)}
                                : {aFifoWr, isaDin};
  wire hostPop = hostRd && !empty && !fwdPop;
  wire doPop = fwdPop || hostPop;

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      fifoMem[wrPtr_r] <= pushWord;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end else begin
      wrPtr_r <= doPush ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
      rdPtr_r <= doPop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
      cnt_r <= (AW+1)'(cnt_r + (doPush ? 1'b1 : 1'b0)
               - (doPop ? 1'b1 : 1'b0));
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  wire svcCond = ectl_r[ECTL_DMAEN] ? (dmaCyc && dmaTc &&
                 (iorStart || iowStart))
               : (dir ? (cnt_r >= RD_TH_C) : (freeCnt >= WR_TH_C));
  wire svcSet = fifoMode && !ectl_r[ECTL_SVC] && svcCond;
  wire [5:0] ectlNxt = ecrWr ? isaDin[7:2] : ectl_r;
  wire faultEdge = faultPrev_r && !faultN;
  wire nErrClr = ecrWr && ectl_r[ECTL_NERR] && !isaDin[4] && !faultN;
  wire errNxt = (mode == MODE_ECP) && !dir && !ectl_r[ECTL_NERR] &&
                faultEdge || (mode == MODE_ECP) && !dir && nErrClr;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dataReg_r <= DATA_RST;
      dcr_r <= DCR_RST;
      ectl_r <= ECTL_RST;
      errIntr_r <= 1'b0;
    end else begin
      dataReg_r <= dataWr ? isaDin : dataReg_r;
      dcr_r <= (iowStart && hDcr) ? isaDin[5:0] : dcr_r;
      // a hardware set wins over a software write of zero; hardware sets the bit only while it is already clear
      ectl_r <= {ectlNxt[5:1], ectlNxt[0] | svcSet};
      errIntr_r <= errNxt;
    end
  end

  // ----------------------------------------------------------------
  // forward engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fwSt_r <= FW_IDLE;
      stbCnt_r <= '0;
      pdOut_r <= DATA_RST;
      tag_r <= 1'b0;
    end else begin
      case (fwSt_r)
        FW_IDLE: begin
          if (fwdPop) begin
            pdOut_r <= head[7:0];
            tag_r <= head[8];
            fwSt_r <= FW_SETUP;
          end
        end
        FW_SETUP: begin
          stbCnt_r <= STB_C;
          fwSt_r <= FW_STB;
        end
        FW_STB: begin
          stbCnt_r <= (stbCnt_r != '0) ? 7'(stbCnt_r - 1'b1) : stbCnt_r;
          if (stbCnt_r == '0 && (mode == MODE_COMPAT_FIFO_PORT || busy)) begin
            fwSt_r <= FW_HOLD;
          end
        end
        FW_HOLD: begin
          if (!busy) begin
            fwSt_r <= FW_IDLE;
          end
        end
        default: fwSt_r <= FW_IDLE;
      endcase
      if (flush) begin
        fwSt_r <= FW_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // reverse engine with run-length expansion
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvSt_r <= RV_IDLE;
      rlePend_r <= 1'b0;
      rleCnt_r <= '0;
      rptLeft_r <= '0;
      rptByte_r <= 8'h00;
    end else begin
      case (rvSt_r)
        RV_IDLE: begin
          if (revMode && !full) begin
            rvSt_r <= RV_REQ;
          end
        end
        RV_REQ: begin
          if (rvCapture) begin
            rvSt_r <= RV_ACK;
            if (busy) begin
              rptByte_r <= pdIn;
              rptLeft_r <= rlePend_r ? rleCnt_r : '0;
              rlePend_r <= 1'b0;
            end else if (!pdIn[7]) begin
              rlePend_r <= 1'b1;
              rleCnt_r <= pdIn[6:0];
            end
          end else if (!revMode) begin
            // drop a stale request once the channel turns forward
            rvSt_r <= RV_IDLE;
          end
        end
        RV_ACK: begin
          if (ackN) begin
            rvSt_r <= (rptLeft_r != '0) ? RV_RPT : RV_IDLE;
          end
        end
        RV_RPT: begin
          if (rptPush) begin
            rptLeft_r <= 7'(rptLeft_r - 1'b1);
          end
          if (rptLeft_r == '0 || (rptLeft_r == 7'h01 && rptPush)) begin
            rvSt_r <= RV_IDLE;
          end
        end
        default: rvSt_r <= RV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // host read path and pins
  // ----------------------------------------------------------------
  wire [7:0] fifoRd = empty ? lastRd_r : head[7:0];
  wire [7:0] rdMux =
    dmaCyc ? fifoRd :
    hData ? ((mode == MODE_SPP || mode == MODE_BIDIR) ? pdIn : 8'h00) :
    hDsr ? {!busy, ackN, pError, select, faultN, 3'b000} :
    hDcr ? {2'b00, dcr_r} :
    hFifo ? ((mode == MODE_CNFG) ? CONFIGURATION_A_VAL : fifoRd) :
    hCnfgB ? ((mode == MODE_CNFG) ? {1'b0, errIntr_r, 6'h00} : 8'h00) :
    hEcr ? {ectl_r, full, empty} : 8'h00;
  wire ecpFwd = (mode == MODE_ECP) && !dir;
  wire pdOeNxt = (mode == MODE_SPP || mode == MODE_COMPAT_FIFO_PORT) ? 1'b1 :
                 (mode == MODE_ECP) ? (ecpFwd && pError) : !dir;
  wire [7:0] pdNxt = (mode == MODE_ECP || mode == MODE_COMPAT_FIFO_PORT) ? pdOut_r :
                     (mode == MODE_TEST) ? head[7:0] : dataReg_r;
  wire stbNxt = (mode == MODE_ECP || mode == MODE_COMPAT_FIFO_PORT) ?
                (fwSt_r != FW_STB) : !dcr_r[DCR_STROBE];
  wire afdNxt = (mode != MODE_ECP) ? !dcr_r[DCR_AUTOFD] :
                dir ? (rvSt_r != RV_REQ) : !tag_r;
  wire dmaNxt = ectl_r[ECTL_DMAEN] && !ectl_r[ECTL_SVC] && fifoMode &&
                (dir ? !empty : !full);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      iorPrev_r <= 1'b1;
      iowPrev_r <= 1'b1;
      faultPrev_r <= 1'b1;
      isaDout_r <= 8'h00;
      isaDoutEn_r <= 1'b0;
      lastRd_r <= 8'h00;
      dmaReq_r <= 1'b0;
      pdOe_r <= 1'b0;
      strobeN_r <= 1'b1;
      autoFdN_r <= 1'b1;
      initN_r <= 1'b1;
      selectInN_r <= 1'b1;
      pdPin_r <= DATA_RST;
    end else begin
      iorPrev_r <= iorN;
      iowPrev_r <= iowN;
      faultPrev_r <= faultN;
      isaDout_r <= iorStart ? rdMux : isaDout_r;
      isaDoutEn_r <= !iorN && (anyHit || dmaCyc);
      lastRd_r <= hostPop ? head[7:0] : lastRd_r;
      dmaReq_r <= dmaNxt;
      pdOe_r <= pdOeNxt;
      pdPin_r <= pdNxt;
      strobeN_r <= stbNxt;
      autoFdN_r <= afdNxt;
      initN_r <= (mode == MODE_ECP) ? !dir : dcr_r[DCR_INIT];
      selectInN_r <= (mode == MODE_ECP) ? 1'b1 : !dcr_r[DCR_SELIN];
    end
  end

  assign isaDout = isaDout_r;
  assign isaDoutEn = isaDoutEn_r;
  assign dmaReq = dmaReq_r;
  assign pdOut = pdPin_r;
  assign pdOe = pdOe_r;
  assign strobeN = strobeN_r;
  assign autoFdN = autoFdN_r;
  assign initN = initN_r;
  assign selectInN = selectInN_r;
  assign errIntr = errIntr_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_fifo_bound: assert property (cnt_r <= DEPTH_C)
    else $error("fifo count beyond depth");
  chk_compat_strobe: assert property (
    fwdPop && mode == MODE_COMPAT_FIFO_PORT |-> ##3 !strobeN_r)
    else $error("compat strobe not asserted after pop");
  chk_ecp_interlock: assert property (
    fwSt_r == FW_STB && $past(fwSt_r) == FW_STB && !busy &&
    mode == MODE_ECP |=> fwSt_r == FW_STB)
    else $error("strobe released before busy");
  chk_rle_count: assert property (
    rvData && rlePend_r && !full |=> rptLeft_r == $past(rleCnt_r))
    else $error("run length count not n plus one");
  chk_init_dir: assert property (
    mode == MODE_ECP && $past(mode) == MODE_ECP |->
    initN_r == $past(!dir))
    else $error("init line does not follow direction");
  chk_selin_ecp: assert property (
    $past(mode) == MODE_ECP |-> selectInN_r)
    else $error("select-in asserted in ECP mode");
  chk_drive_perm: assert property (
    pdOe_r && mode == MODE_ECP && $past(mode) == MODE_ECP |->
    $past(pError) && !$past(dir))
    else $error("data driven without permission");
  chk_aen_qual: assert property (
    $past(aen) && $past(dmaAckN) |-> !isaDoutEn_r)
    else $error("answered during DMA address cycle");
  chk_configuration_a_read: assert property (
    iorStart && hFifo && mode == MODE_CNFG |=> isaDout_r == CONFIGURATION_A_VAL)
    else $error("configuration A value wrong");
  chk_no_compress: assert property (
    iorStart && hCnfgB |=> !isaDout_r[7])
    else $error("compression bit set");

  cov_ecp_fwd: cover property (fwdPop && mode == MODE_ECP ##[1:80]
    fwSt_r == FW_HOLD);
  cov_rle_rev: cover property (rvSt_r == RV_RPT);
  cov_compat: cover property (fwdPop && mode == MODE_COMPAT_FIFO_PORT);
endmodule

//--- verification/ecpph_peer.sv
// behavioural ECP peripheral on the far side of the port
module ecpph_peer (
  input wire logic clk_sys,
  input wire logic [7:0] pdOut,
  input wire logic strobeN,
  input wire logic autoFdN,
  input wire logic initN,
  input wire logic selectInN,
  input wire logic slow,
  input wire logic faultReq,
  output logic [7:0] peerData,
  output logic ackN,
  output logic busy,
  output logic pError,
  output logic select,
  output logic faultN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] fwdQ[$];
  logic [8:0] revQ[$];
  logic [8:0] cur;
  assign select = 1'b1;
  assign faultN = !faultReq;
  // ----------------------------------------------------------------
  // forward: latch on strobe, busy interlock
  // ----------------------------------------------------------------
  initial begin
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (strobeN === 1'b0 && initN === 1'b1) begin
        fwdQ.push_back({autoFdN, pdOut});
        repeat (slow ? 20 : 1) @(posedge clk_sys);
        #1 busy = 1'b1;
        wait (strobeN === 1'b1);
        @(posedge clk_sys);
        #1 busy = 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // reverse: acknowledge request, send queued bytes
  // ----------------------------------------------------------------
  initial begin
    ackN = 1'b1;
    pError = 1'b1;
    peerData = 8'h5a;
    forever begin
      @(posedge clk_sys);
      #1 pError = initN;
      if (!initN && !pError && !autoFdN && selectInN &&
          revQ.size() > 0) begin
        cur = revQ.pop_front();
        peerData = cur[7:0];
        busy = cur[8];
        @(posedge clk_sys);
        #1 ackN = 1'b0;
        wait (autoFdN === 1'b1);
        @(posedge clk_sys);
        #1 ackN = 1'b1;
        peerData = ~cur[7:0];
        busy = 1'b0;
      end
    end
  end
endmodule

//--- verification/ecp_parallel_port_host_bench.sv
// self-checking bench of the extended capabilities parallel port
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      failCount++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module ecp_parallel_port_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ecpph_pkg::*;
  localparam logic [15:0] BASE = 16'h0378;
  logic clk_sys = 1'b0;
  logic resetn, aen, iorN, iowN, dmaAckN, dmaTc, slow, faultReq;
  logic [15:0] isaAddr;
  logic [7:0] isaDin, isaDout, pdIn, pdOut, peerData, q, d;
  logic isaDoutEn, dmaReq, pdOe, strobeN, autoFdN, initN, selectInN;
  logic ackN, busy, pError, select, faultN, errIntr, e, a;
  logic [8:0] expQ[$];
  int seed, failCount, checked, errCnt;

  always #5 clk_sys = ~clk_sys;
  assign pdIn = pdOe ? pdOut : peerData;
  always @(posedge clk_sys) if (errIntr === 1'b1) errCnt++;

  ecpph_port #(.BASE_ADDR(BASE)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .isaAddr(isaAddr), .aen(aen), .iorN(iorN), .iowN(iowN),
    .isaDin(isaDin), .isaDout(isaDout), .isaDoutEn(isaDoutEn),
    .dmaAckN(dmaAckN), .dmaTc(dmaTc), .dmaReq(dmaReq), .pdIn(pdIn),
    .pdOut(pdOut), .pdOe(pdOe), .strobeN(strobeN), .autoFdN(autoFdN),
    .initN(initN), .selectInN(selectInN), .ackN(ackN), .busy(busy),
    .pError(pError), .select(select), .faultN(faultN), .errIntr(errIntr));
  ecpph_peer peer_u (.clk_sys(clk_sys), .pdOut(pdOut), .strobeN(strobeN),
    .autoFdN(autoFdN), .initN(initN), .selectInN(selectInN), .slow(slow),
    .faultReq(faultReq), .peerData(peerData), .ackN(ackN), .busy(busy),
    .pError(pError), .select(select), .faultN(faultN));

  // ----------------------------------------------------------------
  // host bus cycles
  // ----------------------------------------------------------------
  task automatic busCyc(input logic wr, input logic dma,
      input logic [15:0] off, input logic [7:0] din,
      output logic [7:0] dq, output logic de);
    @(posedge clk_sys);
    #1;
    isaAddr = BASE + off;
    isaDin = din;
    dmaAckN = !dma;
    iowN = !wr;
    iorN = wr;
    repeat (3) @(posedge clk_sys);
    dq = isaDout;
    de = isaDoutEn;
    #1;
    iowN = 1'b1;
    iorN = 1'b1;
    dmaAckN = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [15:0] off, input logic [7:0] din);
    logic [7:0] dq;
    logic de;
    busCyc(1'b1, 1'b0, off, din, dq, de);
  endtask
  task automatic rd(input logic [15:0] off);
    busCyc(1'b0, 1'b0, off, 8'h00, q, e);
  endtask
  task automatic fwdChk(input logic useTag);
    logic [8:0] g, x;
    for (int t = 0; t < 20000 && peer_u.fwdQ.size() < expQ.size(); t++)
      @(posedge clk_sys);
    #1;
    `CHK(peer_u.fwdQ.size(), expQ.size())
    while (expQ.size() > 0 && peer_u.fwdQ.size() > 0) begin
      g = peer_u.fwdQ.pop_front();
      x = expQ.pop_front();
      if (!useTag) g[8] = x[8];
      `CHK(g, x)
    end
  endtask
  function automatic logic [3:0] pinExp(input logic [7:0] v);
    // init passes straight, select-in, autofeed and strobe invert
    pinExp = {v[2], ~v[3], ~v[1], ~v[0]};
  endfunction
  task automatic testDone();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failCount++;
    testDone();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 36;
    resetn = 1'b0;
    aen = 1'b0;
    iorN = 1'b1;
    iowN = 1'b1;
    dmaAckN = 1'b1;
    dmaTc = 1'b0;
    slow = 1'b0;
    faultReq = 1'b0;
    isaAddr = 16'h0000;
    isaDin = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(OFF_ECR);
    `CHK(q, {MODE_SPP, 5'b10101})
    for (int m = 0; m < 8; m++) begin
      wr(OFF_ECR, {m[2:0], 5'b10100});
      rd(OFF_ECR);
      `CHK(q[7:5], m[2:0])
    end
    wr(OFF_FIFO, 8'hff);
    rd(OFF_FIFO);
    `CHK(q, 8'h10)
    rd(OFF_CONFIGURATION_B);
    `CHK(q[7], 1'b0)
    wr(OFF_ECR, {MODE_SPP, 5'b10100});
    aen = 1'b1;
    wr(OFF_DCR, 8'h04);
    rd(OFF_DCR);
    `CHK(e, 1'b0)
    aen = 1'b0;
    rd(OFF_DCR);
    `CHK(q, 8'h00)
    rd(16'h0003);
    `CHK(e, 1'b0)
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      wr(OFF_DATA, d);
      rd(OFF_DATA);
      `CHK(q, d)
      wr(OFF_DCR, d);
      `CHK({initN, selectInN, autoFdN, strobeN}, pinExp(d))
      rd(OFF_DCR);
      `CHK(q, {2'b00, d[5:0]})
    end
    wr(OFF_DCR, 8'h04);
    repeat (4) @(posedge clk_sys);
    rd(OFF_DSR);
    `CHK(q, {~busy, ackN, pError, select, faultN, 3'b000})
    wr(OFF_ECR, {MODE_TEST, 5'b10100});
    for (int i = 0; i <= FIFO_DEPTH; i++) wr(OFF_FIFO, 8'h40 + i[7:0]);
    rd(OFF_ECR);
    `CHK(q[1:0], 2'b10)
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd(OFF_FIFO);
      `CHK(q, 8'h40 + i[7:0])
    end
    rd(OFF_ECR);
    `CHK(q[1:0], 2'b01)
    wr(OFF_ECR, {MODE_COMPAT_FIFO_PORT, 5'b10100});
    peer_u.fwdQ.delete();
    for (int i = 0; i < 12; i++) begin
      d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      slow = i[2];
      wr(OFF_FIFO, d);
      expQ.push_back({1'b1, d});
    end
    fwdChk(1'b0);
    slow = 1'b0;
    wr(OFF_ECR, {MODE_ECP, 5'b10100});
    wr(OFF_DCR, 8'h0c);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      a = (i % 3 == 1);
      wr(a ? OFF_DATA : OFF_FIFO, d);
      expQ.push_back({!a, d});
    end
    fwdChk(1'b1);
    `CHK(selectInN, 1'b1)
    faultReq = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(errCnt, 0)
    faultReq = 1'b0;
    wr(OFF_ECR, {MODE_ECP, 5'b00100});
    faultReq = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(errCnt, 1)
    faultReq = 1'b0;
    peer_u.revQ = '{9'h002, 9'h1a5, 9'h081, 9'h13c};
    wr(OFF_DCR, 8'h20);
    `CHK(initN, 1'b0)
    for (int t = 0; t < 2000 && peer_u.revQ.size() > 0; t++)
      @(posedge clk_sys);
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK(pdOe, 1'b0)
    for (int i = 0; i < 4; i++) begin
      rd(OFF_FIFO);
      `CHK(q, (i < 3) ? 8'ha5 : 8'h3c)
    end
    rd(OFF_ECR);
    `CHK(q[0], 1'b1)
    wr(OFF_DCR, 8'h04);
    wr(OFF_ECR, {MODE_COMPAT_FIFO_PORT, 5'b11000});
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(dmaReq, 1'b1)
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      busCyc(1'b1, 1'b1, 16'h0000, d, q, e);
      expQ.push_back({1'b1, d});
    end
    fwdChk(1'b0);
    testDone();
  end
endmodule
